// ==== rtl/mah_host.sv ====
// Host controller that drives a multichannel half-flash converter through its memory-like pins.
// Notes on behaviour
// - Wait mode: host holds channel select stable while chip select and read are low.
// - Wait mode: host stretches its read until the device signals the result is ready, or until TIMEOUT_LIM cycles have passed.
// - Pipelined mode: wait line carries no status; it is grounded, not used.
// - Pipelined mode: host leaves at least 2.5 us between successive reads.
// - Only chip select, read and channel select control the device, as for memory.
`timescale 1ns/1ps
module mah_host
	import mah_pkg::*;
#(
	parameter int unsigned CHAN_W      = 3,
	parameter int unsigned TIMEOUT_LIM = TIMEOUT_CYC
)
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	input  wire logic              i_req_valid,
	input  wire mah_req_t          i_req,
	output logic                   o_req_ready,
	output logic                   o_res_valid,
	output mah_res_t               o_res,
	output logic                   o_timeout,
	output logic                   o_cs_n,
	output logic                   o_rd_n,
	output logic [CHAN_W-1:0]      o_chan_sel,
	input  wire logic [DATA_W-1:0] i_result_bus,
	input  wire logic              i_wait_n,
	input  wire logic              i_done_n
);

	if (CHAN_W < 2 || CHAN_W > CHAN_MAXW)
	begin : g_chk_chan
		$error("CHAN_W must be 2 or 3");
	end
	if (TIMEOUT_LIM <= GAP_CYC || TIMEOUT_LIM >= (1 << CNT_W))
	begin : g_chk_tmo
		$error("TIMEOUT_LIM out of range");
	end

	typedef enum logic [3:0]
	{
		ST_IDLE   = 4'b0001,
		ST_SETUP  = 4'b0010,
		ST_STROBE = 4'b0100,
		ST_GAP    = 4'b1000
	} mah_state_t;

	localparam logic [CNT_W-1:0] CNT_CONV   = CNT_W'(CONV_CYC);
	localparam logic [CNT_W-1:0] CNT_STROBE = CNT_W'(STROBE_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_GAP    = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_TMO    = CNT_W'(TIMEOUT_LIM);

	mah_state_t        state_reg;
	mah_state_t        state_next;
	logic [CNT_W-1:0]  cnt_reg;
	mah_req_t          req_reg;
	logic [CHAN_W-1:0] prev_chan_reg;
	mah_res_t          res_reg;
	logic              res_valid_reg;
	logic              timeout_reg;
	logic              rdy_seen_reg;
	logic [DATA_W-1:0] bus_sync;
	logic [1:0]        stat_sync;

	// The bus passes the same two stages as the status lines, so data and done stay aligned.
	mah_sync #(.WIDTH(DATA_W), .RST_VAL(DATA_RST)) u_sync_bus
	(
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_async (i_result_bus),
		.o_sync  (bus_sync)
	);

	mah_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync_stat
	(
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_async ({i_wait_n, i_done_n}),
		.o_sync  (stat_sync)
	);

	wire wait_rel   = stat_sync[1];
	wire done_low   = ~stat_sync[0];
	wire is_pipe    = (req_reg.mode == MAH_MODE_PIPE);
	// Before the conversion time has run, a low done may be left over from the previous read.
	wire conv_ready = (cnt_reg >= CNT_CONV) && done_low && wait_rel;
	wire tmo_hit    = (cnt_reg == CNT_TMO);
	// The wait line is never looked at in pipelined mode.
	wire pipe_end   = is_pipe && (cnt_reg == CNT_STROBE);
	// Done and data change together at the pins but may resolve an edge apart in the
	// synchronisers, so the bus is taken only once ready has stood for two edges.
	wire ready_held = conv_ready && rdy_seen_reg;
	wire wait_end   = !is_pipe && (ready_held || tmo_hit);
	wire strobe_end = pipe_end || wait_end;
	wire gap_end    = (cnt_reg >= CNT_GAP);
	wire take_req   = i_req_valid && (state_reg == ST_IDLE);
	wire capture    = i_ce && (state_reg == ST_STROBE) && strobe_end;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:   if (i_req_valid) state_next = ST_SETUP;
			ST_SETUP:  state_next = ST_STROBE;
			ST_STROBE: if (strobe_end) state_next = ST_GAP;
			ST_GAP:    if (gap_end) state_next = ST_IDLE;
			default:   state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			state_reg <= ST_IDLE;
		else if (i_ce)
			state_reg <= state_next;
	end

	// The counter runs from the strobe's fall through the gap, so spacing is timed from start.
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			cnt_reg <= '0;
		else if (i_ce)
			cnt_reg <= (state_reg == ST_SETUP) ? '0 : cnt_reg + CNT_W'(1);
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			rdy_seen_reg <= 1'b0;
		else if (i_ce)
			rdy_seen_reg <= conv_ready;
	end

	// Channel changes only in idle, so it is stable across the strobe and its rising edge.
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			req_reg <= REQ_RST;
		else if (i_ce && take_req)
			req_reg <= i_req;
	end

	// A pipelined read returns the conversion started by the read before it.
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			prev_chan_reg <= '0;
		else if (capture)
			prev_chan_reg <= req_reg.chan[CHAN_W-1:0];
	end

	wire [CHAN_W-1:0] res_chan = is_pipe ? prev_chan_reg : req_reg.chan[CHAN_W-1:0];

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			res_reg       <= RES_RST;
			res_valid_reg <= 1'b0;
			timeout_reg   <= 1'b0;
		end
		else if (i_ce)
		begin
			res_valid_reg <= capture;
			timeout_reg   <= capture && wait_end && !ready_held;
			if (capture)
			begin
				res_reg.chan <= CHAN_MAXW'(res_chan);
				res_reg.data <= bus_sync;
			end
		end
	end

	// Both strobes fall and rise together; besides them only channel select steers the device.
	assign o_cs_n      = (state_reg != ST_STROBE);
	assign o_rd_n      = (state_reg != ST_STROBE);
	assign o_chan_sel  = req_reg.chan[CHAN_W-1:0];
	assign o_req_ready = (state_reg == ST_IDLE);
	assign o_res_valid = res_valid_reg;
	assign o_res       = res_reg;
	assign o_timeout   = timeout_reg;

	// Helper: cycles since the last strobe fall, saturating.
	logic [CNT_W-1:0] since_fall_reg;
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			since_fall_reg <= CNT_TMO;
		else if (!o_cs_n && $past(o_cs_n))
			since_fall_reg <= '0;
		else if (since_fall_reg != CNT_TMO)
			since_fall_reg <= since_fall_reg + CNT_W'(1);
	end

	a_chan_stable: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		(!o_cs_n && !$past(o_cs_n)) |-> $stable(o_chan_sel))
		else $error("Channel select moved while the strobe was low.");

	a_read_spacing: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		$fell(o_cs_n) |-> $past(since_fall_reg) >= CNT_GAP)
		else $error("Reads were spaced closer than the least gap.");

	a_strobe_pair: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		(o_cs_n == o_rd_n) && (!$rose(o_rd_n) || $stable(o_chan_sel)))
		else $error("Strobes differ or channel select moved as the read ended.");

	sequence s_pipe_read;
		$fell(o_rd_n) && is_pipe;
	endsequence

	sequence s_pipe_low;
		!o_rd_n [*4] ##1 o_rd_n;
	endsequence

	a_pipe_strobe: assert property (
		@(posedge i_mclk) disable iff (i_rst || !i_ce)
		s_pipe_read |-> s_pipe_low)
		else $error("Pipelined strobe length is wrong.");

	a_wait_extend: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		($rose(o_rd_n) && !is_pipe && !timeout_reg) |-> $past(done_low) && $past(wait_rel))
		else $error("Wait-mode read ended before the device was ready.");

	a_result_pulse: assert property (
		@(posedge i_mclk) disable iff (i_rst || !i_ce)
		$rose(o_rd_n) |-> o_res_valid ##1 !o_res_valid)
		else $error("Result strobe did not follow the end of a read.");

endmodule // mah_host

// ==== rtl/mah_pkg.sv ====
// Package for the multichannel converter host controller: timing, modes and carriers.
package mah_pkg;

	localparam int unsigned CLK_PERIOD_NS = 50;
	// Conversion time of the converter.
	localparam int unsigned T_CONV_NS     = 2000;
	// Least spacing between two read operations in pipelined mode.
	localparam int unsigned T_GAP_NS      = 2500;
	// Low time of a pipelined read strobe; long enough for bus access plus the two sync stages.
	localparam int unsigned T_STROBE_NS   = 200;
	localparam int unsigned T_TIMEOUT_NS  = 200000;

	// Least times round up to whole cycles.
	localparam int unsigned CONV_CYC    = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned GAP_CYC     = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STROBE_CYC  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_CYC = T_TIMEOUT_NS / CLK_PERIOD_NS;

	localparam int unsigned CNT_W     = 16;
	localparam int unsigned CHAN_MAXW = 3;
	localparam int unsigned DATA_W    = 8;

	localparam logic [CHAN_MAXW-1:0] CHAN_RST = 3'h0;
	localparam logic [DATA_W-1:0]    DATA_RST = 8'h00;

	typedef enum logic
	{
		MAH_MODE_WAIT = 1'b0,
		MAH_MODE_PIPE = 1'b1
	} mah_mode_t;

	typedef struct packed
	{
		mah_mode_t              mode;
		logic [CHAN_MAXW-1:0]   chan;
	} mah_req_t;

	typedef struct packed
	{
		logic [CHAN_MAXW-1:0]   chan;
		logic [DATA_W-1:0]      data;
	} mah_res_t;

	localparam mah_req_t REQ_RST = '{mode: MAH_MODE_WAIT, chan: CHAN_RST};
	localparam mah_res_t RES_RST = '{chan: CHAN_RST, data: DATA_RST};

endpackage

// ==== rtl/mah_sync.sv ====
// Two-stage synchroniser for pin inputs, with clock enable.
`timescale 1ns/1ps
module mah_sync
	import mah_pkg::*;
#(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			stage1_reg <= RST_VAL;
			stage2_reg <= RST_VAL;
		end
		else if (i_ce)
		begin
			stage1_reg <= i_async;
			stage2_reg <= stage1_reg;
		end
	end

	assign o_sync = stage2_reg;

endmodule // mah_sync

// ==== tb/mah_dev_model.sv ====
// Behavioural model of the multichannel converter as seen at its memory-like pins.
`timescale 1ns/1ps
module mah_dev_model
	import mah_pkg::*;
(
	input  wire logic        i_mode,
	input  wire logic        i_stall,
	input  wire logic [63:0] i_levels,
	input  wire logic        i_cs_n,
	input  wire logic        i_rd_n,
	input  wire logic [2:0]  i_chan_sel,
	output logic [7:0]       o_result_bus,
	output logic             o_wait_n,
	output logic             o_done_n,
	output logic             o_viol
);
	logic [7:0] result_reg;
	logic [7:0] last_reg;
	logic [7:0] sample;
	logic [2:0] lat_ch;
	logic       ready;
	logic       acc;
	realtime    t_start;
	wire        sel = !i_cs_n && !i_rd_n;
	wire        drive = sel && (i_mode ? acc : ready);

	initial
	begin
		{result_reg, last_reg, sample, lat_ch, ready, acc, o_viol} = '0;
		o_done_n = 1'b1;
		t_start = -1.0e6;
	end

	// A released bus shows the inverse of its last value so that nothing stale can pass.
	assign o_result_bus = drive ? result_reg : ~last_reg;
	assign o_wait_n = i_mode ? 1'b0 : !(sel && !ready);

	always @(posedge sel)
	begin
		if (i_mode && ($realtime - t_start < 2500.0))
			o_viol = 1'b1;
		t_start = $realtime;
		ready = 1'b0;
		if (!i_mode)
			lat_ch = i_chan_sel;
		#1000 sample = i_levels[lat_ch*8 +: 8];
		#1000 if (!i_stall)
		begin
			result_reg = {sample[7:4], 4'h0};
			result_reg = result_reg | (sample - {sample[7:4], 4'h0});
			ready = 1'b1;
			o_done_n = 1'b0;
		end
	end

	// Access time of the pipelined read; the host must not sample earlier.
	always @(sel)
	begin
		acc = 1'b0;
		if (sel)
			#60 acc = 1'b1;
	end

	always @(negedge sel)
	begin
		if (i_mode)
			lat_ch = i_chan_sel;
		o_done_n = 1'b1;
		last_reg = result_reg;
	end

	always @(i_chan_sel)
		if (sel && !i_mode)
			o_viol = 1'b1;
endmodule // mah_dev_model

// ==== tb/multichannel_adc_host_interface_test.sv ====
// Self-checking bench for the converter host controller against the device model.
`timescale 1ns/1ps
module multichannel_adc_host_interface_test;
	import mah_pkg::*;
	typedef struct packed
	{
		mah_req_t   req;
		logic       chk;
		logic [2:0] exp_chan;
	} mah_row_t;
	localparam logic [63:0] LEVELS = 64'hff_a5_5a_81_7e_3c_c3_00;
	localparam mah_row_t ROWS [13] = '{
		'{'{MAH_MODE_WAIT, 3'h0}, 1'b1, 3'h0}, '{'{MAH_MODE_WAIT, 3'h1}, 1'b1, 3'h1},
		'{'{MAH_MODE_WAIT, 3'h2}, 1'b1, 3'h2}, '{'{MAH_MODE_WAIT, 3'h3}, 1'b1, 3'h3},
		'{'{MAH_MODE_WAIT, 3'h4}, 1'b1, 3'h4}, '{'{MAH_MODE_WAIT, 3'h5}, 1'b1, 3'h5},
		'{'{MAH_MODE_WAIT, 3'h6}, 1'b1, 3'h6}, '{'{MAH_MODE_WAIT, 3'h7}, 1'b1, 3'h7},
		'{'{MAH_MODE_PIPE, 3'h5}, 1'b0, 3'h0}, '{'{MAH_MODE_PIPE, 3'h2}, 1'b1, 3'h5},
		'{'{MAH_MODE_PIPE, 3'h7}, 1'b1, 3'h2}, '{'{MAH_MODE_PIPE, 3'h0}, 1'b1, 3'h7},
		'{'{MAH_MODE_PIPE, 3'h0}, 1'b1, 3'h0}};

	logic       mclk, rst, ce, req_valid, req_ready, res_valid, timeout, cs_n, rd_n;
	logic       wait_n, done_n, dev_mode, stall, viol, to;
	logic [2:0] chan_sel;
	logic [7:0] bus;
	mah_req_t   req;
	mah_res_t   res, r;
	int         n_errors, samples_checked, cycles;

	mah_host #(.CHAN_W(3), .TIMEOUT_LIM(60)) mah_host_i (.i_mclk(mclk), .i_rst(rst), .i_ce(ce),
		.i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready), .o_res_valid(res_valid),
		.o_res(res), .o_timeout(timeout), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_chan_sel(chan_sel),
		.i_result_bus(bus), .i_wait_n(wait_n), .i_done_n(done_n));
	mah_dev_model mah_dev_model_i (.i_mode(dev_mode), .i_stall(stall), .i_levels(LEVELS),
		.i_cs_n(cs_n), .i_rd_n(rd_n), .i_chan_sel(chan_sel), .o_result_bus(bus),
		.o_wait_n(wait_n), .o_done_n(done_n), .o_viol(viol));

	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic final_report;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A wedged handshake ends the run here rather than hanging.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			n_errors++;
			final_report();
		end
	end

	task automatic cmp_res(input mah_res_t e, input mah_res_t g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR result exp %h got %h", e, g);
		end
	endtask

	task automatic cmp_bit(input string name, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s exp %b got %b", name, e, g);
		end
	endtask

	task automatic do_req(input mah_req_t q, output mah_res_t rr, output logic tt);
		int k;
		k = 0;
		dev_mode = q.mode;
		req = q;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && k < 500)
		begin
			@(negedge mclk);
			k++;
		end
		@(negedge mclk);
		req_valid = 1'b0;
		while (res_valid !== 1'b1 && k < 500)
		begin
			@(negedge mclk);
			k++;
		end
		cmp_bit("answer", 1'b1, res_valid);
		rr = res;
		tt = timeout;
	endtask

	initial
	begin
		{req_valid, dev_mode, stall, n_errors, samples_checked, cycles} = '0;
		req = REQ_RST;
		ce = 1'b1;
		rst = 1'b1;
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		cmp_bit("cs_n", 1'b1, cs_n);
		cmp_bit("req_ready", 1'b1, req_ready);
		foreach (ROWS[i])
		begin
			do_req(ROWS[i].req, r, to);
			if (ROWS[i].chk)
				cmp_res('{chan: ROWS[i].exp_chan, data: LEVELS[ROWS[i].exp_chan*8 +: 8]}, r);
			cmp_bit("timeout", 1'b0, to);
		end
		// A converter that never finishes must not hang the host.
		stall = 1'b1;
		do_req('{MAH_MODE_WAIT, 3'h1}, r, to);
		cmp_bit("timeout", 1'b1, to);
		stall = 1'b0;
		// A long freeze mid-read must hold the strobe past the point where it would have ended.
		fork
			do_req('{MAH_MODE_WAIT, 3'h4}, r, to);
			begin
				repeat (10) @(negedge mclk);
				ce = 1'b0;
				repeat (50) @(negedge mclk);
				cmp_bit("cs_n", 1'b0, cs_n);
				ce = 1'b1;
			end
		join
		cmp_res('{chan: 3'h4, data: LEVELS[39:32]}, r);
		// Reset in the middle of a pipelined strobe.
		dev_mode = 1'b1;
		req = '{MAH_MODE_PIPE, 3'h3};
		req_valid = 1'b1;
		while (req_ready !== 1'b1)
			@(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
		repeat (2) @(negedge mclk);
		cmp_bit("rd_n", 1'b0, rd_n);
		rst = 1'b1;
		@(negedge mclk);
		cmp_bit("rd_n", 1'b1, rd_n);
		cmp_bit("res_valid", 1'b0, res_valid);
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		repeat (50) @(negedge mclk);
		do_req('{MAH_MODE_WAIT, 3'h6}, r, to);
		cmp_res('{chan: 3'h6, data: LEVELS[55:48]}, r);
		cmp_bit("viol", 1'b0, viol);
		final_report();
	end
endmodule // multichannel_adc_host_interface_test
